// [design/igtul_axil_slave.sv]
`timescale 1ns/10ps
module igtul_axil_slave (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [12:0] s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [12:0] s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	igtul_reg_if.bus         rb
);

	logic        aw_held_reg;
	logic        w_held_reg;
	logic [12:0] awaddr_reg;
	logic [7:0]  wdata_reg;
	logic        wstrb0_reg;
	logic        wr_fire;
	logic        wr_aligned;
	logic        rd_aligned;

	// Each write channel is held separately so address and data may arrive in either order.
	assign s_axil_awready = !aw_held_reg;
	assign s_axil_wready  = !w_held_reg;
	assign s_axil_arready = !s_axil_rvalid;
	assign wr_fire        = aw_held_reg && w_held_reg && !s_axil_bvalid;
	assign wr_aligned     = (awaddr_reg[1:0] == 2'h0);
	assign rd_aligned     = (s_axil_araddr[1:0] == 2'h0);

	// Only byte lane 0 carries register data; a write without it changes nothing.
	assign rb.wr_en   = wr_fire && wr_aligned && wstrb0_reg && rb.wr_ok;
	assign rb.wr_idx  = awaddr_reg[12:2];
	assign rb.wr_data = wdata_reg;
	assign rb.rd_idx  = s_axil_araddr[12:2];

	// Write address capture.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= 13'h0000;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axil_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	// Write data capture.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axil_wdata[7:0];
			wstrb0_reg <= s_axil_wstrb[0];
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	// Write response; unaligned or unmapped addresses answer with a slave error.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= igtul_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp  <= (wr_aligned && rb.wr_ok) ? igtul_pkg::RESP_OKAY : igtul_pkg::RESP_SLVERR;
		end else if (s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	// Read channel; data is sampled at the address handshake, reads have no side effects.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h00000000;
			s_axil_rresp  <= igtul_pkg::RESP_OKAY;
		end else if (s_axil_arvalid && s_axil_arready) begin
			s_axil_rvalid <= 1'b1;
			if (rd_aligned && rb.rd_ok) begin
				s_axil_rdata <= {24'h000000, rb.rd_data};
				s_axil_rresp <= igtul_pkg::RESP_OKAY;
			end else begin
				s_axil_rdata <= 32'h00000000;
				s_axil_rresp <= igtul_pkg::RESP_SLVERR;
			end
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end

endmodule

// [design/igtul_pkg.sv]
package igtul_pkg;

	// Geometry of the group tables.
	localparam int MAX_GROUPS    = 16;
	localparam int GRP_PER_LOCK  = 4;
	localparam int TX_ELEMS      = 8;
	localparam int RX_ELEMS      = 4;
	localparam int SIZE_W        = 3;
	localparam int IDX_W         = 11;
	localparam int ADDR_W        = 13;

	// Register indices of the four lock registers; byte address is four times the index.
	localparam logic [10:0] LOCK_IDX_1_TO_4   = 11'h41F;
	localparam logic [10:0] LOCK_IDX_5_TO_8   = 11'h51F;
	localparam logic [10:0] LOCK_IDX_9_TO_12  = 11'h61F;
	localparam logic [10:0] LOCK_IDX_13_TO_16 = 11'h71F;

	// Index field layout of the table windows.
	localparam logic [2:0] BLOCK_FIRST = 3'h4;
	localparam logic [2:0] TX_ROW      = 3'h1;
	localparam logic [3:0] RX_ROW      = 4'hD;
	localparam logic [2:0] TX_CTL_ELEM = 3'h1;
	localparam int         TX_EN_BIT   = 7;

	// Reset values.
	localparam logic [7:0] LOCK_RST  = 8'h00;
	localparam logic [7:0] TABLE_RST = 8'h00;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DEC_NONE,
		DEC_LOCK,
		DEC_TX,
		DEC_RX
	} igtul_kind_t;

	typedef struct packed {
		igtul_kind_t kind;
		logic [3:0]  group;
		logic [2:0]  elem;
		logic [1:0]  lockno;
	} igtul_dec_t;

endpackage

// [design/igtul_reg_if.sv]
`timescale 1ns/10ps
interface igtul_reg_if;
	logic        wr_en;
	logic [10:0] wr_idx;
	logic [7:0]  wr_data;
	logic        wr_ok;
	logic [10:0] rd_idx;
	logic [7:0]  rd_data;
	logic        rd_ok;

	modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx,
	              input wr_ok, input rd_data, input rd_ok);
	modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx,
	              output wr_ok, output rd_data, output rd_ok);
endinterface

// [design/igtul_top.sv]
`timescale 1ns/10ps
// Contract
// - Each update-enable bit reads 1 while its table is being updated, else 0.
// - Bit returns to 0 after all elements written; software writing 0 is accepted.
// - Lock register one: bits 0-3 transmit groups 1-4, bits 4-7 receive groups 1-4.
// - Lock register two: bits 0-3 transmit groups 5-8, bits 4-7 receive groups 5-8.
// - Lock register three: bits 0-3 transmit groups 9-12, bits 4-7 receive groups 9-12.
// - Lock register four: bits 0-3 transmit groups 13-16, bits 4-7 receive 13-16.
// - Lock bits of groups the variant lacks are not defined.
// - Transmit control element low three bits give configured links minus one.
module igtul_top #(
	parameter int NUM_GROUPS = 16
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [12:0] s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output logic             s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output logic             s_axil_wready,
	output logic [1:0]       s_axil_bresp,
	output logic             s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [12:0] s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output logic             s_axil_arready,
	output logic [31:0]      s_axil_rdata,
	output logic [1:0]       s_axil_rresp,
	output logic             s_axil_rvalid,
	input  wire logic        s_axil_rready,
	output logic [15:0]      tx_lock,
	output logic [15:0]      rx_lock,
	output logic [47:0]      tx_group_size,
	output logic [15:0]      tx_group_enable
);

	localparam int NG = igtul_pkg::MAX_GROUPS;

	igtul_reg_if rb ();

	logic [15:0] tx_lock_reg;
	logic [15:0] rx_lock_reg;
	logic [15:0] tx_prev_reg;
	logic [15:0] rx_prev_reg;
	logic [7:0]  tx_seen_reg [NG];
	logic [3:0]  rx_seen_reg [NG];
	logic [7:0]  tx_stage_reg [NG][igtul_pkg::TX_ELEMS];
	logic [7:0]  tx_live_reg [NG][igtul_pkg::TX_ELEMS];
	logic [7:0]  rx_stage_reg [NG][igtul_pkg::RX_ELEMS];
	logic [7:0]  rx_live_reg [NG][igtul_pkg::RX_ELEMS];
	logic [15:0] grp_mask;
	logic [15:0] tx_wr;
	logic [15:0] rx_wr;
	logic [15:0] tx_done;
	logic [15:0] rx_done;
	logic [15:0] lock_wr;
	igtul_pkg::igtul_dec_t wd;
	igtul_pkg::igtul_dec_t rd;

	// Turns a register index into a lock register, a table element, or nothing.
	function automatic igtul_pkg::igtul_dec_t decode(input logic [10:0] idx);
		igtul_pkg::igtul_dec_t d;
		logic [10:0]           lock_idx [4];
		d.kind      = igtul_pkg::DEC_NONE;
		d.group     = 4'h0;
		d.elem      = 3'h0;
		d.lockno    = idx[9:8];
		lock_idx[0] = igtul_pkg::LOCK_IDX_1_TO_4;
		lock_idx[1] = igtul_pkg::LOCK_IDX_5_TO_8;
		lock_idx[2] = igtul_pkg::LOCK_IDX_9_TO_12;
		lock_idx[3] = igtul_pkg::LOCK_IDX_13_TO_16;
		if (idx[10:8] >= igtul_pkg::BLOCK_FIRST) begin
			if (idx == lock_idx[idx[9:8]]) begin
				d.kind = igtul_pkg::DEC_LOCK;
			end else if (idx[7:5] == igtul_pkg::TX_ROW) begin
				d.kind  = igtul_pkg::DEC_TX;
				d.group = {idx[9:8], idx[4:3]};
				d.elem  = idx[2:0];
			end else if (idx[7:4] == igtul_pkg::RX_ROW) begin
				d.kind  = igtul_pkg::DEC_RX;
				d.group = {idx[9:8], idx[3:2]};
				d.elem  = {1'b0, idx[1:0]};
			end
		end
		return d;
	endfunction

	// A table access is mapped only for groups that this variant builds.
	function automatic logic mapped(input igtul_pkg::igtul_dec_t d);
		logic ok;
		ok = 1'b0;
		if (d.kind == igtul_pkg::DEC_LOCK) begin
			ok = 1'b1;
		end else if (d.kind != igtul_pkg::DEC_NONE) begin
			ok = ({1'b0, d.group} < 5'(NUM_GROUPS));
		end
		return ok;
	endfunction

	igtul_axil_slave u_axil (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.rb             (rb)
	);

	// Per-group write strobes and completion detection.
	always_comb begin
		wd       = decode(rb.wr_idx);
		rd       = decode(rb.rd_idx);
		rb.wr_ok = mapped(wd);
		rb.rd_ok = mapped(rd);
		for (int g = 0; g < NG; g++) begin
			grp_mask[g] = (g < NUM_GROUPS);
			lock_wr[g]  = rb.wr_en && (wd.kind == igtul_pkg::DEC_LOCK) && (wd.lockno == 2'(g / 4)) && grp_mask[g];
			tx_wr[g]    = rb.wr_en && (wd.kind == igtul_pkg::DEC_TX) && (wd.group == 4'(g));
			rx_wr[g]    = rb.wr_en && (wd.kind == igtul_pkg::DEC_RX) && (wd.group == 4'(g));
			tx_done[g]  = tx_lock_reg[g] && tx_wr[g] && ((tx_seen_reg[g] | (8'h01 << wd.elem)) == 8'hFF);
			rx_done[g]  = rx_lock_reg[g] && rx_wr[g] && ((rx_seen_reg[g] | (4'h1 << wd.elem[1:0])) == 4'hF);
		end
	end

	// Lock bits. A software write in the same cycle as the automatic release wins.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_lock_reg <= {2{igtul_pkg::LOCK_RST}};
			rx_lock_reg <= {2{igtul_pkg::LOCK_RST}};
		end else begin
			for (int g = 0; g < NG; g++) begin
				if (lock_wr[g]) begin
					tx_lock_reg[g] <= rb.wr_data[g % 4];
					rx_lock_reg[g] <= rb.wr_data[4 + g % 4];
				end else begin
					if (tx_done[g]) begin
						tx_lock_reg[g] <= 1'b0;
					end
					if (rx_done[g]) begin
						rx_lock_reg[g] <= 1'b0;
					end
				end
			end
		end
	end

	// Element tracking: a fresh lock starts an empty record of rewritten elements.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int g = 0; g < NG; g++) begin
				tx_seen_reg[g] <= 8'h00;
				rx_seen_reg[g] <= 4'h0;
			end
		end else begin
			for (int g = 0; g < NG; g++) begin
				if ((lock_wr[g] && !tx_lock_reg[g]) || tx_done[g]) begin
					tx_seen_reg[g] <= 8'h00;
				end else if (tx_wr[g] && tx_lock_reg[g]) begin
					tx_seen_reg[g] <= tx_seen_reg[g] | (8'h01 << wd.elem);
				end
				if ((lock_wr[g] && !rx_lock_reg[g]) || rx_done[g]) begin
					rx_seen_reg[g] <= 4'h0;
				end else if (rx_wr[g] && rx_lock_reg[g]) begin
					rx_seen_reg[g] <= rx_seen_reg[g] | (4'h1 << wd.elem[1:0]);
				end
			end
		end
	end

	// Falling-edge history of the lock bits drives the commit one cycle later.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_prev_reg <= {2{igtul_pkg::LOCK_RST}};
			rx_prev_reg <= {2{igtul_pkg::LOCK_RST}};
		end else begin
			tx_prev_reg <= tx_lock_reg;
			rx_prev_reg <= rx_lock_reg;
		end
	end

	// Staged tables take every write; software reads back what it wrote.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int g = 0; g < NG; g++) begin
				for (int e = 0; e < igtul_pkg::TX_ELEMS; e++) tx_stage_reg[g][e] <= igtul_pkg::TABLE_RST;
				for (int e = 0; e < igtul_pkg::RX_ELEMS; e++) rx_stage_reg[g][e] <= igtul_pkg::TABLE_RST;
			end
		end else begin
			for (int g = 0; g < NG; g++) begin
				if (tx_wr[g]) begin
					tx_stage_reg[g][wd.elem] <= rb.wr_data;
				end
				if (rx_wr[g]) begin
					rx_stage_reg[g][wd.elem[1:0]] <= rb.wr_data;
				end
			end
		end
	end

	// Live tables: frozen while locked so the datapath never sees a half-written table.
	// An unlocked write goes straight through, since nothing guards it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int g = 0; g < NG; g++) begin
				for (int e = 0; e < igtul_pkg::TX_ELEMS; e++) tx_live_reg[g][e] <= igtul_pkg::TABLE_RST;
				for (int e = 0; e < igtul_pkg::RX_ELEMS; e++) rx_live_reg[g][e] <= igtul_pkg::TABLE_RST;
			end
		end else begin
			for (int g = 0; g < NG; g++) begin
				if (tx_prev_reg[g] && !tx_lock_reg[g]) begin
					tx_live_reg[g] <= tx_stage_reg[g];
				end
				if (tx_wr[g] && !tx_lock_reg[g]) begin
					tx_live_reg[g][wd.elem] <= rb.wr_data;
				end
				if (rx_prev_reg[g] && !rx_lock_reg[g]) begin
					rx_live_reg[g] <= rx_stage_reg[g];
				end
				if (rx_wr[g] && !rx_lock_reg[g]) begin
					rx_live_reg[g][wd.elem[1:0]] <= rb.wr_data;
				end
			end
		end
	end

	// Read mux; lock bits of absent groups read as zero.
	always_comb begin
		rb.rd_data = 8'h00;
		case (rd.kind)
			igtul_pkg::DEC_LOCK: begin
				for (int b = 0; b < igtul_pkg::GRP_PER_LOCK; b++) begin
					rb.rd_data[b]     = tx_lock[{rd.lockno, 2'(b)}];
					rb.rd_data[4 + b] = rx_lock[{rd.lockno, 2'(b)}];
				end
			end
			igtul_pkg::DEC_TX: rb.rd_data = tx_stage_reg[rd.group][rd.elem];
			igtul_pkg::DEC_RX: rb.rd_data = rx_stage_reg[rd.group][rd.elem[1:0]];
			default: rb.rd_data = 8'h00;
		endcase
	end

	// Outputs toward the group datapath; size and enable from committed state, lock bits from the lock registers masked to the built groups.
	always_comb begin
		tx_lock = tx_lock_reg & grp_mask;
		rx_lock = rx_lock_reg & grp_mask;
		for (int g = 0; g < NG; g++) begin
			tx_group_size[g * igtul_pkg::SIZE_W +: igtul_pkg::SIZE_W] =
				tx_live_reg[g][igtul_pkg::TX_CTL_ELEM][igtul_pkg::SIZE_W - 1:0];
			tx_group_enable[g] = tx_live_reg[g][igtul_pkg::TX_CTL_ELEM][igtul_pkg::TX_EN_BIT];
		end
	end

endmodule

// [tb/igtul_properties.sv]
`timescale 1ns/10ps
// Watches the bus handshakes and the lock and commit outputs of the top module.
module igtul_properties #(
	parameter int NUM_GROUPS = 16
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        s_axil_bvalid,
	input wire logic        s_axil_bready,
	input wire logic        s_axil_arvalid,
	input wire logic        s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic        s_axil_rvalid,
	input wire logic        s_axil_rready,
	input wire logic [15:0] tx_lock,
	input wire logic [15:0] rx_lock,
	input wire logic [47:0] tx_group_size
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Lock bits are cleared by reset, so the first free cycle shows none set.
	lock_reset_a: assert property ($fell(sys_rst) |-> tx_lock == 16'h0 && rx_lock == 16'h0)
		else $error("lock bits set after reset");
	// A lock bit only moves at the edge where a write completes.
	lock_write_a: assert property ($changed({tx_lock, rx_lock}) |-> $rose(s_axil_bvalid))
		else $error("lock bits moved without a write");
	// Locked table of group 0 keeps its committed size; new values wait for the unlock.
	commit_frozen_a: assert property (tx_lock[0] && $past(tx_lock[0]) |-> $stable(tx_group_size[2:0]))
		else $error("committed size moved while locked");
	// Bits of absent groups never rise.
	absent_groups_a: assert property (((tx_lock | rx_lock) >> NUM_GROUPS) == 16'h0)
		else $error("lock bit of absent group set");
	write_resp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
		else $error("write response dropped early");
	read_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data not held");
	read_latency_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid ##0 !s_axil_arready)
		else $error("read answer late");
	read_cause_a: assert property ($rose(s_axil_rvalid) |-> $past(s_axil_arvalid && s_axil_arready))
		else $error("read answer without request");
	read_width_a: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
endmodule

bind igtul_top igtul_properties #(.NUM_GROUPS(NUM_GROUPS)) u_props (
	.clk(clk), .sys_rst(sys_rst), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
	.s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .tx_lock(tx_lock), .rx_lock(rx_lock),
	.tx_group_size(tx_group_size)
);

// [tb/test_ima_group_table_update_lock.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_ima_group_table_update_lock;
	logic        clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [12:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, resp;
	logic [15:0] tx_lock, rx_lock, tx_group_enable, tx_lock2, rx_lock2;
	logic [47:0] tx_group_size;
	logic [7:0]  rdat;
	int          error_cnt, comparisons;
	// Rows: lock register byte address, value written, expected transmit and receive lock vectors.
	logic [12:0] row_addr [4] = '{13'h107C, 13'h147C, 13'h187C, 13'h1C7C};
	logic [7:0]  row_val  [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3F};
	logic [15:0] row_tx   [4] = '{16'h000A, 16'h0030, 16'h0600, 16'hF000};
	logic [15:0] row_rx   [4] = '{16'h0005, 16'h00C0, 16'h0900, 16'h3000};

	igtul_top #(.NUM_GROUPS(16)) DUT (
		.clk(clk), .sys_rst(sys_rst), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
		.s_axil_rvalid(rvalid), .s_axil_rready(rready), .tx_lock(tx_lock), .rx_lock(rx_lock),
		.tx_group_size(tx_group_size), .tx_group_enable(tx_group_enable)
	);

	// A two-group build shares the bus inputs; its handshakes keep step with the full build, cycle for cycle.
	igtul_top #(.NUM_GROUPS(2)) DUT2 (
		.clk(clk), .sys_rst(sys_rst), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(),
		.s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(),
		.s_axil_bresp(), .s_axil_bvalid(), .s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arvalid(arvalid), .s_axil_arready(), .s_axil_rdata(), .s_axil_rresp(),
		.s_axil_rvalid(), .s_axil_rready(rready), .tx_lock(tx_lock2), .rx_lock(rx_lock2),
		.tx_group_size(), .tx_group_enable()
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Ready is raised only once the answer is seen, so the slave must hold it meanwhile.
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b1;
		@(posedge clk);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [12:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b1;
		@(posedge clk);
		rdat = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic do_reset;
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask

	task automatic end_of_test;
		$display("Counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Each bus access takes a handful of cycles; this span is far beyond the whole sequence.
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test;
	end

	initial begin
		{sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = '0;
		error_cnt = 0;
		comparisons = 0;
		do_reset;
		`CHK({tx_lock, rx_lock, tx_group_size, tx_group_enable}, 96'h0)
		for (int i = 0; i < 4; i++) begin
			rd(row_addr[i]);
			`CHK(rdat, 8'h00)
			wr(row_addr[i], row_val[i]);
			`CHK({tx_lock, rx_lock}, {row_tx[i], row_rx[i]})
			`CHK({tx_lock2, rx_lock2}, {row_tx[i] & 16'h0003, row_rx[i] & 16'h0003})
			rd(row_addr[i]);
			`CHK(rdat, row_val[i])
			wr(row_addr[i], 8'h00);
			`CHK({resp, tx_lock, rx_lock}, {igtul_pkg::RESP_OKAY, 32'h0})
			`CHK({tx_lock2, rx_lock2}, 32'h0)
		end
		// Unlocked write lands at once; a locked rewrite stays hidden until the eighth element.
		wr(13'h1084, 8'h82);
		`CHK({tx_group_enable[0], tx_group_size[2:0]}, 4'hA)
		wr(13'h107C, 8'h01);
		for (int e = 0; e < 8; e++) begin
			`CHK({tx_lock[0], tx_group_size[2:0]}, 4'hA)
			wr(13'h1080 + 13'(4 * e), (e == 1) ? 8'h05 : 8'h10);
		end
		`CHK(tx_lock[0], 1'b0)
		repeat (2) @(posedge clk);
		`CHK({tx_group_enable[0], tx_group_size[2:0]}, 4'h5)
		// Receive lock bit of group two clears after its four elements are written.
		wr(13'h107C, 8'h20);
		for (int e = 0; e < 4; e++) begin
			`CHK(rx_lock, 16'h0002)
			wr(13'h1350 + 13'(4 * e), 8'h33);
		end
		`CHK(rx_lock, 16'h0000)
		rd(13'h0000);
		`CHK(resp, igtul_pkg::RESP_SLVERR)
		rd(13'h107D);
		`CHK(resp, igtul_pkg::RESP_SLVERR)
		wr(13'h0004, 8'hFF);
		`CHK(resp, igtul_pkg::RESP_SLVERR)
		// Reset in mid-run must drop locks that software left set.
		wr(13'h147C, 8'hFF);
		`CHK({tx_lock, rx_lock, tx_lock2, rx_lock2}, {16'h00F0, 16'h00F0, 32'h0})
		do_reset;
		rd(13'h147C);
		`CHK({rdat, tx_lock, rx_lock}, 40'h0)
		end_of_test;
	end
endmodule
